// >>> hw/dhp_port.v
// Host port pin decoder: bus style latch, strobe decode, data/command routing
// Behaviour
// - Chip select is active low; bus activity accepted only while it is low.
// - Init input low runs internal initialisation; host keeps it high normally.
// - Selector high: the data-bus byte is display data.
// - Selector low: the data-bus byte goes into the command register.
// - In I2C mode the selector pin gives the target address lsb.
// - In 6800 mode the direction pin high means read, low means write.
// - In 8080 mode the direction pin is an active-low write strobe.
// - In 6800 mode the enable pin high with chip select starts a transfer.
// - In 8080 mode the enable pin is an active-low read strobe.
`timescale 1ns/10ps
`include "dhp_map.vh"
module dhp_port #(
    parameter [7:0] STRAP_MAP = `DHP_STRAP_MAP
) (
    // Clock and reset
    input  wire       mclk,
    input  wire       resetn,
    // Interface straps
    input  wire       iface_select_a,
    input  wire       iface_select_b,
    // Host pins
    input  wire       cs_n,
    input  wire       init_in_n,
    input  wire       dc_sel,
    input  wire       rw_wr_n,
    input  wire       en_rd_n,
    input  wire [7:0] data_in,
    output reg  [7:0] data_out,
    output reg        data_oe_n,
    // Core side
    input  wire [7:0] read_byte,
    output reg  [1:0] mode_r,
    output reg        init_busy_r,
    output reg        data_wr_r,
    output reg  [7:0] data_byte_r,
    output reg        cmd_wr_r,
    output reg  [7:0] cmd_byte_r,
    output reg        rd_req_r,
    output reg        rd_is_data_r,
    output reg        target_addr_lsb,
    output reg        strap_err_r
);
    ////////////////////////////////////////////////////////////////////////
    // Session state
    reg        mode_valid_r;
    reg        mode_valid_nxt;
    reg  [1:0] mode_nxt;
    reg        init_busy_nxt;
    reg        rd_active_r;
    reg        rd_active_nxt;
    // Strobes accepted in this cycle
    reg        wr_go;
    reg        rd_go;
    // Next values of the registered outputs
    reg        data_wr_nxt;
    reg  [7:0] data_byte_nxt;
    reg        cmd_wr_nxt;
    reg  [7:0] cmd_byte_nxt;
    reg        rd_req_nxt;
    reg        rd_is_data_nxt;
    reg        addr_lsb_nxt;
    reg        strap_err_nxt;
    reg        data_oe_n_nxt;

    wire       e_start;
    wire       wr_start;
    wire       rd_start;
    wire [2:0] strap_idx = {iface_select_b, iface_select_a, 1'b0};
    wire [1:0] strap_mode = STRAP_MAP[strap_idx +: 2];
    wire       selected = ~cs_n & mode_valid_r & init_in_n;
    // Style decode of the latched mode
    wire       style_6800 = (mode_r == `DHP_MODE_6800);
    wire       style_i2c = (mode_r == `DHP_MODE_I2C);
    wire       serial_style = (mode_r == `DHP_MODE_SERIAL) | style_i2c;
    // Read strobe level that keeps the bus driven: enable high, or read low
    wire       rd_strobe_on = style_6800 ? en_rd_n : ~en_rd_n;

    // Edge detectors qualify strobes so one pulse makes one transfer
    dhp_edge #(.ACTIVE_HIGH(1)) u_e_edge (
        .mclk   (mclk),
        .resetn (resetn),
        .strobe (en_rd_n),
        .start  (e_start)
    );
    dhp_edge #(.ACTIVE_HIGH(0)) u_wr_edge (
        .mclk   (mclk),
        .resetn (resetn),
        .strobe (rw_wr_n),
        .start  (wr_start)
    );
    dhp_edge #(.ACTIVE_HIGH(0)) u_rd_edge (
        .mclk   (mclk),
        .resetn (resetn),
        .strobe (en_rd_n),
        .start  (rd_start)
    );

    ////////////////////////////////////////////////////////////////////////
    always @* begin
        wr_go = 1'b0;
        rd_go = 1'b0;
        case (mode_r)
            `DHP_MODE_6800: begin
                wr_go = selected & e_start & ~rw_wr_n;
                rd_go = selected & e_start & rw_wr_n;
            end
            `DHP_MODE_8080: begin
                wr_go = selected & wr_start;
                rd_go = selected & rd_start & rw_wr_n;
            end
            default: begin
                // Serial styles: both strobe pins are grounded by the host
                wr_go = 1'b0;
                rd_go = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode is latched from the straps on the first edge after init and then
    // held; moving the straps mid-session has no effect until the next init
    always @* begin
        mode_nxt       = mode_r;
        mode_valid_nxt = mode_valid_r;
        init_busy_nxt  = 1'b0;
        // A low init input clears the latch so the straps are read again
        if (!init_in_n) begin
            mode_valid_nxt = 1'b0;
            init_busy_nxt  = 1'b1;
        end else if (!mode_valid_r) begin
            mode_nxt       = strap_mode;
            mode_valid_nxt = 1'b1;
        end
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            mode_r       <= `DHP_MODE_6800;
            mode_valid_r <= 1'b0;
            init_busy_r  <= 1'b1;
        end else begin
            mode_r       <= mode_nxt;
            mode_valid_r <= mode_valid_nxt;
            init_busy_r  <= init_busy_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always @* begin
        // One-cycle pulses, one per accepted strobe
        data_wr_nxt    = wr_go & dc_sel;
        cmd_wr_nxt     = wr_go & ~dc_sel;
        rd_req_nxt     = rd_go;

        // Each byte and the read flag hold until the next accepted transfer of their kind; the address bit is set below
        data_byte_nxt  = data_byte_r;
        cmd_byte_nxt   = cmd_byte_r;
        rd_is_data_nxt = rd_is_data_r;
        addr_lsb_nxt   = target_addr_lsb;
        if (wr_go && dc_sel) begin
            data_byte_nxt = data_in;
        end
        if (wr_go && !dc_sel) begin
            cmd_byte_nxt = data_in;
        end
        if (rd_go) begin
            rd_is_data_nxt = dc_sel;
        end

        // Address bit follows the pin only once the I2C style is latched
        if (mode_valid_r && style_i2c) begin
            addr_lsb_nxt = dc_sel;
        end
        // Flags a host that leaves a strobe high in a serial style
        strap_err_nxt = mode_valid_r & serial_style & (rw_wr_n | en_rd_n);

        // Bus stays driven only while the read strobe is held with chip select low
        rd_active_nxt = rd_active_r;
        if (rd_go) begin
            rd_active_nxt = 1'b1;
        end else if (cs_n || !rd_strobe_on) begin
            rd_active_nxt = 1'b0;
        end
        data_oe_n_nxt = ~(rd_go | (rd_active_r & ~cs_n & rd_strobe_on));
    end

    // Init low clears the transfer side like a reset but keeps the latched mode
    // The core byte is copied every cycle outside reset and init low; the host sees it only while data_oe_n is low
    always @(posedge mclk) begin
        if (!resetn || !init_in_n) begin
            // Pulses clear and the data bus is released
            data_wr_r       <= 1'b0;
            cmd_wr_r        <= 1'b0;
            rd_req_r        <= 1'b0;
            rd_is_data_r    <= 1'b0;
            data_byte_r     <= `DHP_BYTE_RST;
            cmd_byte_r      <= `DHP_BYTE_RST;
            target_addr_lsb <= 1'b0;
            strap_err_r     <= 1'b0;
            rd_active_r     <= 1'b0;
            data_out        <= `DHP_BYTE_RST;
            data_oe_n       <= 1'b1;
        end else begin
            data_wr_r       <= data_wr_nxt;
            cmd_wr_r        <= cmd_wr_nxt;
            rd_req_r        <= rd_req_nxt;
            rd_is_data_r    <= rd_is_data_nxt;
            data_byte_r     <= data_byte_nxt;
            cmd_byte_r      <= cmd_byte_nxt;
            target_addr_lsb <= addr_lsb_nxt;
            strap_err_r     <= strap_err_nxt;
            rd_active_r     <= rd_active_nxt;
            data_out        <= read_byte;
            data_oe_n       <= data_oe_n_nxt;
        end
    end
endmodule // dhp_port

// >>> hw/dhp_map.vh
// Constants for the display host port pin decoder
`ifndef DHP_MAP_VH
`define DHP_MAP_VH

// Bus style codes held in the latched mode register
`define DHP_MODE_6800    2'h0
`define DHP_MODE_8080    2'h1
`define DHP_MODE_SERIAL  2'h2
`define DHP_MODE_I2C     2'h3
`define DHP_MODE_W       2

// Default strap-to-mode map: {iface_select_b, iface_select_a} selects an entry
`define DHP_STRAP_MAP    8'hE4

// Reset values
`define DHP_BYTE_RST     8'h00

`endif

// >>> hw/dhp_edge.v
// Strobe edge detector with selectable active level
`timescale 1ns/10ps
module dhp_edge #(
    parameter ACTIVE_HIGH = 1
) (
    // Clock and reset
    input  wire mclk,
    input  wire resetn,
    // Strobe
    input  wire strobe,
    output wire start
);
    reg prev_r;

    wire active = ACTIVE_HIGH ? strobe : ~strobe;

    always @(posedge mclk) begin
        if (!resetn) begin
            // Start as if the strobe were active: one held through reset is no new transfer
            prev_r <= 1'b1;
        end else begin
            prev_r <= active;
        end
    end

    assign start = active & ~prev_r;
endmodule // dhp_edge

// >>> testbench/dhp_port_chk.sv
// Checker for the host port decoder
`timescale 1ns/10ps
`include "dhp_map.vh"
module dhp_port_chk (
    // Clock and reset
    input logic       mclk,
    input logic       resetn,
    // Host pins
    input logic       cs_n,
    input logic       init_in_n,
    input logic       dc_sel,
    input logic       rw_wr_n,
    input logic       en_rd_n,
    input logic [7:0] data_in,
    input logic       data_oe_n,
    // Core side
    input logic [1:0] mode_r,
    input logic       init_busy_r,
    input logic       data_wr_r,
    input logic [7:0] data_byte_r,
    input logic       cmd_wr_r,
    input logic [7:0] cmd_byte_r,
    input logic       rd_req_r,
    input logic       target_addr_lsb
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    wire go = !cs_n && init_in_n && !init_busy_r;
    sequence s_wr80; go && mode_r == `DHP_MODE_8080 && $fell(rw_wr_n); endsequence
    sequence s_rd80; go && mode_r == `DHP_MODE_8080 && $fell(en_rd_n) && rw_wr_n; endsequence
    sequence s_en68; go && mode_r == `DHP_MODE_6800 && $rose(en_rd_n); endsequence
    property p_en68;
        s_en68 |=> rd_req_r == $past(rw_wr_n) && (data_wr_r || cmd_wr_r) != $past(rw_wr_n);
    endproperty
    a_cs_quiet: assert property ($past(cs_n) |-> !(data_wr_r || cmd_wr_r || rd_req_r))
        else $error("pulse while deselected");
    a_init_busy: assert property (!init_in_n |=> init_busy_r)
        else $error("not busy in init");
    a_data_route: assert property (data_wr_r |-> $past(dc_sel) && data_byte_r == $past(data_in))
        else $error("bad data write");
    a_cmd_route: assert property (cmd_wr_r |-> !$past(dc_sel) && cmd_byte_r == $past(data_in))
        else $error("bad command write");
    a_addr_lsb: assert property (mode_r == `DHP_MODE_I2C && go |=> target_addr_lsb == $past(dc_sel))
        else $error("address bit stale");
    a_en_strobe: assert property (p_en68)
        else $error("enable strobe lost");
    a_wr_strobe: assert property (s_wr80 |=> data_wr_r || cmd_wr_r)
        else $error("write strobe lost");
    a_rd_strobe: assert property (s_rd80 |=> rd_req_r && !data_oe_n)
        else $error("read strobe lost");
    a_mode_held: assert property (init_in_n && !init_busy_r |=> $stable(mode_r))
        else $error("mode changed");
endmodule // dhp_port_chk
bind dhp_port dhp_port_chk chk (.*);

// >>> testbench/dhp_host.sv
// Host model driving the display port pins
`timescale 1ns/10ps
`include "dhp_map.vh"
module dhp_host (
    input  logic       mclk,
    output logic       cs_n, dc_sel, rw_wr_n, en_rd_n,
    output logic [7:0] data_in
);
    initial {cs_n, dc_sel, rw_wr_n, en_rd_n, data_in} = 12'hE00;
    // Serial styles keep both strobes grounded
    task automatic idle(input logic [1:0] m);
        rw_wr_n = (m == `DHP_MODE_8080);
        en_rd_n = (m == `DHP_MODE_8080);
    endtask
    task automatic xfer(input logic [1:0] m, input logic s, r, d, input logic [7:0] b);
        @(negedge mclk);
        cs_n = !s;
        dc_sel = d;
        data_in = b;
        if (m == `DHP_MODE_6800) begin
            rw_wr_n = r;
            en_rd_n = 1'b1;
        end else if (m == `DHP_MODE_8080) begin
            rw_wr_n = r;
            en_rd_n = !r;
        end
        @(negedge mclk);
        cs_n = 1'b1;
        data_in = ~b;
        idle(m);
    endtask
endmodule // dhp_host

// >>> testbench/tb_dhp_port.sv
// Testbench for the host port decoder
`timescale 1ns/10ps
`include "dhp_map.vh"
module tb_dhp_port;
    logic       mclk = 0, resetn = 0, iface_select_a = 0, iface_select_b = 0, init_in_n = 0;
    logic [7:0] read_byte = 8'h00;
    wire        cs_n, dc_sel, rw_wr_n, en_rd_n, data_oe_n, init_busy_r, data_wr_r, cmd_wr_r, rd_req_r;
    wire        rd_is_data_r, target_addr_lsb, strap_err_r;
    wire  [7:0] data_in, data_out, data_byte_r, cmd_byte_r;
    wire  [1:0] mode_r;
    int         err_count = 0, n_checks = 0;
    dhp_host host (.*);
    dhp_port uut (.*);
    initial forever #50 mclk = ~mclk;
    function automatic logic [7:0] exp_pulse(input logic s, r, d);
        return s ? (r ? 8'h04 : d ? 8'h02 : 8'h01) : 8'h00;
    endfunction
    task chk(input logic [7:0] g, e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task end_sim;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge mclk);
        err_count++;
        end_sim;
    end
    initial begin
        logic [1:0] m;
        logic       s, r, d;
        logic [7:0] b;
        void'($urandom(32'hAEE7EDDB));
        repeat (3) @(negedge mclk);
        resetn = 1;
        for (int k = 0; k < 4; k++) begin
            init_in_n = 0;
            {iface_select_b, iface_select_a} = 2'(k);
            m = 2'(`DHP_STRAP_MAP >> (2 * k));
            host.idle(m);
            @(negedge mclk);
            chk(8'(init_busy_r), 8'h01);
            init_in_n = 1;
            repeat (2) @(negedge mclk);
            // Straps move after the latch; the mode must not follow
            {iface_select_b, iface_select_a} = 2'($urandom);
            for (int i = 0; i < 16; i++) begin
                {s, r, d, b, read_byte} = 19'($urandom);
                s = s | i[0];
                host.xfer(m, s, r, d, b);
                s = s && m < `DHP_MODE_SERIAL;
                chk(8'({rd_req_r, data_wr_r, cmd_wr_r}), exp_pulse(s, r, d));
                chk(8'(mode_r), 8'(m));
                if (m == `DHP_MODE_I2C) chk(8'(target_addr_lsb), 8'(d));
                if (s && !r) chk(d ? data_byte_r : cmd_byte_r, b);
                if (s && r) chk(data_out, read_byte);
                if (s && r) chk(8'({data_oe_n, rd_is_data_r}), 8'(d));
            end
            // Corner case: a strobe left high is flagged only in serial styles
            host.rw_wr_n = 1'b1;
            @(negedge mclk);
            chk(8'(strap_err_r), 8'(m >= `DHP_MODE_SERIAL));
            host.idle(m);
            @(negedge mclk);
            chk(8'(strap_err_r), 8'h00);
        end
        end_sim;
    end
endmodule // tb_dhp_port
